// File: supply_monitor.sv
// The register offsets and the plain strobed port were decided locally.
`include "supply_monitor_consts.svh"
`default_nettype none
module supply_monitor (
  input  wire logic                            clk,                        // system clock, 100 MHz
  input  wire logic                            rst_b,                      // async reset, active low
  input  wire supply_monitor_pkg::comparator_s cmp,                        // analog comparator outputs
  input  wire logic                            monitor_power_enable,       // configuration: monitor on
  input  wire logic                            undervoltage_reset_enable,  // configuration: reset allowed
  input  wire logic [7:0]                      addr,                       // register address
  input  wire logic [7:0]                      wdata,                      // write data
  input  wire logic                            wr,                         // write strobe
  input  wire logic                            rd,                         // read strobe
  output logic [7:0]                           rdata_ff,                   // read data, cycle after rd
  output logic                                 reset_req_ff,               // reset request to system
  output logic                                 reset_pin_o_ff,             // external reset pin level
  output logic                                 reset_pin_oe_b_ff           // pin enable, low drives
);
  import supply_monitor_pkg::*;

  // ==========================================================
  // input synchronisers: comparator is asynchronous to clk
  comparator_s cmp_meta_ff;
  comparator_s cmp_sync_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_meta_ff <= '0;
      cmp_sync_ff <= '0;
    end else begin
      cmp_meta_ff <= cmp;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // ==========================================================
  // trip point select register
  logic trip_point_select_ff;
  logic trip_prev_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_point_select_ff <= 1'b0;
    end else if (wr && addr == `MSC_OFFSET) begin
      trip_point_select_ff <= wdata[`MSC_TRIP_BIT];
    end
  end

  // ==========================================================
  // pick comparator pair for the selected tolerance
  function automatic logic sel_low(input comparator_s c, input logic tight);
    sel_low = tight ? c.below_trip_tight : c.below_trip_loose;
  endfunction
  function automatic logic sel_recov(input comparator_s c, input logic tight);
    sel_recov = tight ? c.above_recov_tight : c.above_recov_loose;
  endfunction
  logic low_now;
  logic recov_now;
  assign low_now   = sel_low(cmp_sync_ff, trip_point_select_ff);
  assign recov_now = sel_recov(cmp_sync_ff, trip_point_select_ff);

  // ==========================================================
  // consecutive-cycle filter; no enable gating needed beyond power bit,
  // and it ignores wait/stop since the clock keeps running here
  logic [5:0] low_count;
  supply_filter u_filter (
    .clk      (clk),
    .rst_b    (rst_b),
    .enable   (monitor_power_enable),
    .low      (low_now),
    .count_ff (low_count)
  );

  // ==========================================================
  // tolerance change with both enables low: reset if now below new trip
  logic trip_changed;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_prev_ff <= 1'b0;
    end else begin
      trip_prev_ff <= trip_point_select_ff;
    end
  end
  assign trip_changed = (trip_prev_ff != trip_point_select_ff) && !monitor_power_enable
                        && !undervoltage_reset_enable;

  // ==========================================================
  // reset request: set after filter, held until one cycle above recovery
  logic nxt_reset_req;
  always_comb begin
    if (reset_req_ff) begin
      nxt_reset_req = !recov_now;
    end else begin
      nxt_reset_req = (monitor_power_enable && undervoltage_reset_enable
                       && low_count >= `RESET_FILTER_CYCLES - 6'h01 && low_now)
                      || (trip_changed && low_now);
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_req_ff <= 1'b0;
    end else begin
      reset_req_ff <= nxt_reset_req;
    end
  end

  // ==========================================================
  // external reset pin: driven low while the request stands, released otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_pin_o_ff    <= 1'b1;
      reset_pin_oe_b_ff <= 1'b1;
    end else begin
      reset_pin_o_ff    <= !nxt_reset_req;
      reset_pin_oe_b_ff <= !nxt_reset_req;
    end
  end

  // ==========================================================
  // undervoltage flag: set at the 36th low cycle, inside the 32..40 window
  logic undervoltage_flag_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      undervoltage_flag_ff <= 1'b0;
    end else if (recov_now) begin
      undervoltage_flag_ff <= 1'b0;
    end else if (low_count >= `FLAG_FILTER_CYCLES - 6'h01 && low_now) begin
      undervoltage_flag_ff <= 1'b1;
    end
  end

  // ==========================================================
  // register read; flag bit ignores writes, no interrupt source exists
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= `MSC_RESET;
    end else if (rd && addr == `MSC_OFFSET) begin
      rdata_ff <= '0;
      rdata_ff[`MSC_FLAG_BIT] <= undervoltage_flag_ff;
      rdata_ff[`MSC_TRIP_BIT] <= trip_point_select_ff;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  AST_RST_AFTER_NINE: assert property (@(posedge clk) disable iff (!rst_b)
    monitor_power_enable && undervoltage_reset_enable && low_now && low_count == 6'h08
    |=> reset_req_ff) else $error("reset not raised after nine low cycles");
  AST_NO_EARLY_RST: assert property (@(posedge clk) disable iff (!rst_b)
    !reset_req_ff && !trip_changed && low_count < 6'h08 |=> !reset_req_ff)
    else $error("reset raised too early");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
    reset_req_ff && recov_now |=> !reset_req_ff) else $error("reset not released");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    reset_req_ff && !recov_now |=> reset_req_ff) else $error("reset dropped early");
  AST_PIN_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    reset_req_ff |-> !reset_pin_o_ff && !reset_pin_oe_b_ff) else $error("pin not driven");
  AST_PIN_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !reset_req_ff |-> reset_pin_o_ff && reset_pin_oe_b_ff) else $error("pin driven without request");
  AST_TRIP_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    wr && addr == `MSC_OFFSET |=> trip_point_select_ff == $past(wdata[0]))
    else $error("trip select not written");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
    low_now && !recov_now && low_count == 6'h27 |=> undervoltage_flag_ff)
    else $error("flag not set after 40 cycles");
  AST_FLAG_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    !undervoltage_flag_ff && low_count < 6'h1F |=> !undervoltage_flag_ff)
    else $error("flag set too early");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    recov_now |=> !undervoltage_flag_ff) else $error("flag not cleared");
  AST_POWER_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !monitor_power_enable |=> low_count == 6'h00) else $error("filter ran while off");
  AST_READ: assert property (@(posedge clk) disable iff (!rst_b)
    rd && addr == `MSC_OFFSET |=> rdata_ff[`MSC_FLAG_BIT] == $past(undervoltage_flag_ff))
    else $error("flag read mismatch");
  COV_RESET: cover property (@(posedge clk) disable iff (!rst_b) $rose(reset_req_ff));
  COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_b) $fell(reset_req_ff));
  COV_FLAG: cover property (@(posedge clk) disable iff (!rst_b) $rose(undervoltage_flag_ff));
  COV_TRIP: cover property (@(posedge clk) disable iff (!rst_b) trip_changed && low_now);
endmodule
`default_nettype wire

// File: supply_monitor_consts.svh
// Function
// - monitor is active straight out of reset without software action
// - comparator is filtered only while monitor_power_enable is 1
// - reset requested after nine or more consecutive low-supply cycles when enabled
// - reset held until supply above recovery level; one cycle there releases it
// - external active-low reset pin driven low during any undervoltage reset
// - trip_point_select resets to 0 (10 percent); writing 1 selects 5 percent
// - flag 0 under 32 low cycles, 1 beyond 40, cleared above recovery
// - any device reset clears the undervoltage flag
// - undervoltage flag is read-only; writes to it have no effect
// - with both enables 0, tolerance change below new trip causes reset
// - monitor never raises an interrupt; only reset request and flag
// - in wait mode an enabled monitor keeps running and can reset
// - in stop mode an enabled monitor keeps running and can reset
`ifndef SUPPLY_MONITOR_CONSTS_SVH
`define SUPPLY_MONITOR_CONSTS_SVH
// ==========================================================
// register map
`define MSC_OFFSET      8'h00
`define MSC_RESET       8'h00
`define MSC_FLAG_BIT    3
`define MSC_TRIP_BIT    0
// ==========================================================
// filter counts, in clk cycles
`define RESET_FILTER_CYCLES 6'h09
`define FLAG_FILTER_CYCLES  6'h24
`define FILTER_MAX          6'h3F
`endif

// File: supply_monitor_pkg.sv
`default_nettype none
package supply_monitor_pkg;
  // comparator samples from the analog side
  typedef struct packed {
    logic below_trip_tight;   // supply at or below tight trip
    logic below_trip_loose;   // supply at or below loose trip
    logic above_recov_tight;  // supply above tight trip plus hysteresis
    logic above_recov_loose;  // supply above loose trip plus hysteresis
  } comparator_s;
  typedef logic [7:0] reg_data_t;
endpackage
`default_nettype wire

// File: supply_filter.sv
`include "supply_monitor_consts.svh"
`default_nettype none
module supply_filter (
  input  wire logic       clk,      // system clock
  input  wire logic       rst_b,    // async reset, active low
  input  wire logic       enable,   // monitor powered
  input  wire logic       low,      // synchronised low-supply sample
  output logic [5:0]      count_ff  // consecutive low cycles, saturating
);
  import supply_monitor_pkg::*;
  logic [5:0] nxt_count;
  // ==========================================================
  // saturating count; a single high sample restarts it, so noise spikes never add up
  always_comb begin
    if (!enable || !low) begin
      nxt_count = 6'h00;
    end else if (count_ff == `FILTER_MAX) begin
      nxt_count = count_ff;
    end else begin
      nxt_count = count_ff + 6'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= 6'h00;
    end else begin
      count_ff <= nxt_count;
    end
  end
  AST_FILTER_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    !low |=> count_ff == 6'h00) else $error("filter not cleared");
  AST_FILTER_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    enable && low && count_ff != `FILTER_MAX |=> count_ff == $past(count_ff) + 6'h01)
    else $error("filter did not advance");
endmodule
`default_nettype wire

// File: supply_comparator_model.sv
`default_nettype none
module supply_comparator_model (
  input  wire logic [2:0]                level, // supply level code, 0 is lowest
  output supply_monitor_pkg::comparator_s cmp   // comparator levels to the monitor
);
  timeunit 1ns;
  timeprecision 1ps;
  import supply_monitor_pkg::*;
  // ==========================================================
  // thresholds
  // tight pair sits above the loose pair; level 3 or 5 lies in a hysteresis band
  // one driver for the whole struct keeps the output a single continuous assignment
  assign cmp = '{below_trip_tight:  (level <= 3'h4),
                 below_trip_loose:  (level <= 3'h2),
                 above_recov_tight: (level >  3'h5),
                 above_recov_loose: (level >  3'h3)};
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_monitor_pkg::*;
  typedef struct {logic p; logic e; logic s; logic [2:0] lv; int n; logic rq; logic fl;} row_s;
  logic        clk        = 1'h0;
  logic        rst_b      = 1'h0;
  logic [2:0]  level      = 3'h7;
  logic        pwr        = 1'h1;
  logic        rst_en     = 1'h0;
  logic        wr         = 1'h0;
  logic        rd         = 1'h0;
  logic [7:0]  addr       = 8'h00;
  logic [7:0]  wdata      = 8'h00;
  logic [7:0]  rdata_ff;
  logic [7:0]  got;
  logic        req;
  logic        pin_o;
  logic        oe_b;
  comparator_s cmp;
  int          fail_count = 0;
  int          tests_run  = 0;
  // power, reset enable, trip select, low level, low cycles, expected request, expected flag
  row_s rows [7] = '{'{1'h1, 1'h1, 1'h0, 3'h0, 8, 1'h0, 1'h0}, '{1'h1, 1'h1, 1'h0, 3'h0, 9, 1'h1, 1'h0},
                     '{1'h1, 1'h0, 1'h0, 3'h0, 41, 1'h0, 1'h1}, '{1'h1, 1'h0, 1'h0, 3'h0, 31, 1'h0, 1'h0},
                     '{1'h0, 1'h1, 1'h0, 3'h0, 41, 1'h0, 1'h0}, '{1'h1, 1'h1, 1'h1, 3'h4, 9, 1'h1, 1'h0},
                     '{1'h1, 1'h1, 1'h0, 3'h4, 20, 1'h0, 1'h0}};
  // ==========================================================
  // clock and instances
  always #5 clk = ~clk;
  supply_comparator_model supply_comparator_model_i (.level(level), .cmp(cmp));
  supply_monitor supply_monitor_i (.clk(clk), .rst_b(rst_b), .cmp(cmp), .monitor_power_enable(pwr),
    .undervoltage_reset_enable(rst_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff),
    .reset_req_ff(req), .reset_pin_o_ff(pin_o), .reset_pin_oe_b_ff(oe_b));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'h1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    rd   <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 got = rdata_ff;
  endtask
  // level is taken at the next edge and held for n samples
  task automatic hold(input logic [2:0] lv, input int n);
    @(posedge clk);
    level <= lv;
    repeat (n - 1) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    foreach (rows[i]) begin
      @(posedge clk);
      rst_b  <= 1'h0;
      pwr    <= rows[i].p;
      rst_en <= rows[i].e;
      @(posedge clk);
      rst_b <= 1'h1;
      reg_rd(8'h00);
      check(got, 8'h00);
      reg_wr(8'h00, {7'h00, rows[i].s});
      hold(rows[i].lv, rows[i].n);
      hold(rows[i].s ? 3'h5 : 3'h3, 4);
      reg_rd(8'h00);
      check(got, {4'h0, rows[i].fl, 2'h0, rows[i].s});
      check({5'h00, req, pin_o, oe_b}, {5'h00, rows[i].rq, ~rows[i].rq, ~rows[i].rq});
      hold(3'h7, 1);
      hold(rows[i].s ? 3'h5 : 3'h3, 4);
      check({7'h00, req}, 8'h00);
    end
    // lift the supply first, else the tight trip chosen below would count the band level as low
    hold(3'h7, 4);
    // the flag bit ignores writes and unused bits read zero
    reg_wr(8'h00, 8'hFF);
    reg_rd(8'h00);
    check(got, 8'h01);
    @(posedge clk);
    #1 check(rdata_ff, 8'h00);
    // an unmapped place neither stores nor answers
    reg_wr(8'h5A, 8'h00);
    reg_rd(8'h00);
    check(got, 8'h01);
    reg_rd(8'h5A);
    check(got, 8'h00);
    // one sample above the trip restarts the filter, so two runs of five never add up
    reg_wr(8'h00, 8'h00);
    hold(3'h0, 5);
    hold(3'h3, 1);
    hold(3'h0, 5);
    hold(3'h3, 4);
    check({7'h00, req}, 8'h00);
    // with both enables off, moving the trip above the supply raises a reset
    @(posedge clk);
    pwr    <= 1'h0;
    rst_en <= 1'h0;
    hold(3'h4, 4);
    reg_wr(8'h00, 8'h01);
    repeat (3) @(posedge clk);
    #1 check({7'h00, req}, 8'h01);
    hold(3'h7, 4);
    check({7'h00, req}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
